//--- core/twi_master_regs.vh
`ifndef TWI_MASTER_REGS_VH
`define TWI_MASTER_REGS_VH

// register byte offsets
`define OFF_CONTROL      12'h000
`define OFF_MODE         12'h004
`define OFF_CLOCK        12'h010
`define OFF_STATUS       12'h020
`define OFF_INT_ENABLE   12'h024
`define OFF_INT_CLEAR    12'h028
`define OFF_TRANSMIT     12'h034
`define OFF_RECEIVE      12'h030

// control word bits
`define CTL_START        0
`define CTL_STOP         1
`define CTL_MASTER_EN    2
`define CTL_MASTER_DIS   3
`define CTL_SOFT_RESET   7

// mode word fields
`define MODE_READ        12
`define MODE_ADDR_LO     16
`define MODE_ADDR_HI     22

// clock word fields
`define CLK_LOW_LO       0
`define CLK_LOW_HI       7
`define CLK_HIGH_LO      8
`define CLK_HIGH_HI      15
`define CLK_EXP_LO       16
`define CLK_EXP_HI       18

// status word bits
`define ST_COMPLETE      0
`define ST_RX_READY      1
`define ST_TX_READY      2
`define ST_NOT_ACKNOWLEDGED_FLAG          8

// event status bits
`define EV_COMPLETE      0
`define EV_NOT_ACKNOWLEDGED_FLAG          1
`define EV_RX_READY      2

// reset values and limits
`define CLOCK_RESET      32'h0000_0404
`define DIVIDER_LIMIT    8191

`endif

//--- core/two_wire_master_controller.v
`timescale 1ns/10ps
`include "twi_master_regs.vh"

//Contract
// R1: software keeps each clock divider times two to the exponent at or below 8191.
// R2: writing the master-disable bit as one freezes any transfer at once.
// R3: disabling leaves transfer-complete and transmit-ready flags unchanged.
// R4: software waits for the transfer end and masks interrupts before disabling.
// R5: a status read between a not-acknowledge and transfer-complete loses the not_acknowledged_flag flag.
// R6: transfer-complete and not_acknowledged_flag set together; a status read clears not_acknowledged_flag.
// R7: software learns of completion by interrupt and does not poll during a transfer.
// R8: the receive word loads on every data byte, so a transmit byte overwrites it.
// R9: that overwrite raises neither receive-ready nor receive-overrun.
// R10: software reads a received byte before transmitting new data.
// R11: a software reset during a frame with the clock low blocks all later transfers.
// R12: clock low and high phases are the dividers times two to the exponent.
module two_wire_master_controller (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        scl_in,
    output reg         scl_out,
    output reg         scl_oe,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    output reg         irq
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_BIT   = 3'h2;
    localparam [2:0] ST_ACK   = 3'h3;
    localparam [2:0] ST_STOP  = 3'h4;
    localparam [2:0] ST_STUCK = 3'h5;

    reg        master_enabled;
    reg        read_mode;
    reg [6:0]  slave_addr;
    reg [31:0] clock_cfg;
    reg [7:0]  tx_data;
    reg [7:0]  receive_holding_word;
    reg        transfer_complete_flag;
    reg        transmit_ready_flag;
    reg        receive_ready_flag;
    reg        not_acknowledged_flag;
    reg        not_acknowledged_flag_pending;
    reg        stop_request;
    reg [2:0]  event_status;
    reg [2:0]  event_enable;
    reg [2:0]  state;
    reg [3:0]  bit_cnt;
    reg        addr_phase;
    reg [7:0]  shift;
    reg        phase_high;
    reg [15:0] phase_cnt;
    reg        scl_meta;
    reg        scl_sync;
    reg        sda_meta;
    reg        sda_sync;

    wire       access    = psel & penable;
    wire       wr        = access & pwrite;
    wire       rd        = access & ~pwrite;
    wire       ctl_wr    = wr & (paddr == `OFF_CONTROL);
    wire       status_rd = rd & (paddr == `OFF_STATUS);
    wire       tx_wr     = wr & (paddr == `OFF_TRANSMIT);
    wire       rx_rd     = rd & (paddr == `OFF_RECEIVE);
    wire       freeze    = ctl_wr & pwdata[`CTL_MASTER_DIS];
    wire       soft_rst  = ctl_wr & pwdata[`CTL_SOFT_RESET];
    wire [7:0] clk_low   = clock_cfg[`CLK_LOW_HI:`CLK_LOW_LO];
    wire [7:0] clk_high  = clock_cfg[`CLK_HIGH_HI:`CLK_HIGH_LO];
    wire [2:0] clk_exp   = clock_cfg[`CLK_EXP_HI:`CLK_EXP_LO];
    wire       mapped    = (paddr == `OFF_CONTROL) | (paddr == `OFF_MODE) |
                           (paddr == `OFF_CLOCK) | (paddr == `OFF_STATUS) |
                           (paddr == `OFF_INT_ENABLE) | (paddr == `OFF_INT_CLEAR) |
                           (paddr == `OFF_TRANSMIT) | (paddr == `OFF_RECEIVE);

    reg [15:0] phase_len;
    reg [31:0] next_prdata;
    reg [2:0]  next_event;

    // phase length is divider shifted by exponent, zero divider still gives one cycle
    always @* begin
        if (phase_high)
            phase_len = {8'h00, clk_high} << clk_exp; // R12
        else
            phase_len = {8'h00, clk_low} << clk_exp; // R12
        if (phase_len == 16'h0000)
            phase_len = 16'h0001;
    end

    wire phase_done = (phase_cnt + 16'h0001 >= phase_len);
    // the clock only advances once the line really shows the level we released
    wire line_ok    = phase_high ? scl_sync : 1'b1;
    wire tick       = phase_done & line_ok;
    wire running    = (state != ST_IDLE) && (state != ST_STUCK);

    always @* begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            `OFF_MODE:       next_prdata = {9'h000, slave_addr, 3'h0, read_mode, 12'h000};
            `OFF_CLOCK:      next_prdata = clock_cfg;
            `OFF_STATUS: begin
                next_prdata[`ST_COMPLETE] = transfer_complete_flag;
                next_prdata[`ST_RX_READY] = receive_ready_flag;
                next_prdata[`ST_TX_READY] = transmit_ready_flag;
                next_prdata[`ST_NOT_ACKNOWLEDGED_FLAG]     = not_acknowledged_flag;
            end
            `OFF_INT_ENABLE: next_prdata = {29'h0000_0000, event_enable};
            `OFF_RECEIVE:    next_prdata = {24'h00_0000, receive_holding_word};
            default:         next_prdata = 32'h0000_0000;
        endcase
    end

    // two flops on each pin before anything looks at it
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
        end
    end

    // apb answers in the first access cycle
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            master_enabled         <= 1'b0;
            read_mode              <= 1'b0;
            slave_addr             <= 7'h00;
            clock_cfg              <= `CLOCK_RESET;
            tx_data                <= 8'h00;
            receive_holding_word   <= 8'h00;
            transfer_complete_flag <= 1'b1;
            transmit_ready_flag    <= 1'b1;
            receive_ready_flag     <= 1'b0;
            not_acknowledged_flag  <= 1'b0;
            not_acknowledged_flag_pending           <= 1'b0;
            stop_request           <= 1'b0;
            event_enable           <= 3'h0;
            state                  <= ST_IDLE;
            bit_cnt                <= 4'h0;
            addr_phase             <= 1'b0;
            shift                  <= 8'h00;
            phase_high             <= 1'b1;
            phase_cnt              <= 16'h0000;
            scl_out                <= 1'b1;
            scl_oe                 <= 1'b0;
            sda_out                <= 1'b1;
            sda_oe                 <= 1'b0;
        end else if (soft_rst) begin
            master_enabled <= 1'b0;
            read_mode      <= 1'b0;
            slave_addr     <= 7'h00;
            clock_cfg      <= `CLOCK_RESET;
            event_enable   <= 3'h0;
            not_acknowledged_flag_pending   <= 1'b0;
            stop_request   <= 1'b0;
            // a reset taken with the clock held low leaves the engine wedged
            if (running && !scl_out)
                state <= ST_STUCK; // R11
            else if (state != ST_STUCK)
                state <= ST_IDLE; // R11
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            scl_out <= 1'b1;
            sda_out <= 1'b1;
        end else begin
            if (ctl_wr && pwdata[`CTL_MASTER_EN])
                master_enabled <= 1'b1;
            // disable only drops the enable, flags keep their values
            if (freeze)
                master_enabled <= 1'b0; // R3
            if (wr && paddr == `OFF_MODE) begin
                read_mode  <= pwdata[`MODE_READ];
                slave_addr <= pwdata[`MODE_ADDR_HI:`MODE_ADDR_LO];
            end
            if (wr && paddr == `OFF_CLOCK)
                clock_cfg <= pwdata;
            if (wr && paddr == `OFF_INT_ENABLE)
                event_enable <= pwdata[2:0];
            if (ctl_wr && pwdata[`CTL_STOP])
                stop_request <= 1'b1;
            if (tx_wr) begin
                tx_data             <= pwdata[7:0];
                transmit_ready_flag <= 1'b0;
            end
            if (rx_rd)
                receive_ready_flag <= 1'b0;
            // a status read both clears the flag and cancels a pending not_acknowledged_flag
            if (status_rd) begin
                not_acknowledged_flag <= 1'b0; // R6
                not_acknowledged_flag_pending          <= 1'b0; // R5
            end

            if (freeze) begin
                // frozen mid-frame: pins and counters hold where they are
                state <= state; // R2
            end else if (state != ST_IDLE && state != ST_STUCK && master_enabled) begin
                phase_cnt <= tick ? 16'h0000 : phase_cnt + 16'h0001;
            end

            if (!freeze && master_enabled) begin
                case (state)
                    ST_IDLE: begin
                        if (ctl_wr && pwdata[`CTL_START]) begin
                            state                  <= ST_START;
                            transfer_complete_flag <= 1'b0;
                            sda_oe                 <= 1'b1;
                            sda_out                <= 1'b0;
                            phase_high             <= 1'b1;
                            phase_cnt              <= 16'h0000;
                            // a stop written with the start is kept, an older one is dropped
                            stop_request           <= pwdata[`CTL_STOP];
                        end
                    end
                    ST_START: begin
                        if (tick) begin
                            state      <= ST_BIT;
                            addr_phase <= 1'b1;
                            shift      <= {slave_addr, read_mode};
                            bit_cnt    <= 4'h0;
                            scl_oe     <= 1'b1;
                            scl_out    <= 1'b0;
                            phase_high <= 1'b0;
                        end
                    end
                    ST_BIT, ST_ACK: begin
                        // data moves one cycle into the low phase, clear of both clock edges
                        if (!phase_high && phase_cnt == 16'h0000) begin
                            if (state == ST_BIT)
                                sda_oe <= ~(read_mode & ~addr_phase) & ~shift[7];
                            else
                                sda_oe <= read_mode & ~addr_phase & ~stop_request;
                            sda_out <= 1'b0;
                        end
                        if (tick && !phase_high) begin
                            scl_oe     <= 1'b0;
                            scl_out    <= 1'b1;
                            phase_high <= 1'b1;
                        end else if (tick) begin
                            scl_oe     <= 1'b1;
                            scl_out    <= 1'b0;
                            phase_high <= 1'b0;
                            if (state == ST_BIT) begin
                                shift   <= {shift[6:0], sda_sync};
                                bit_cnt <= bit_cnt + 4'h1;
                                if (bit_cnt == 4'h7)
                                    state <= ST_ACK;
                            end else begin
                                // the holding word loads whatever the direction was
                                if (!addr_phase) begin
                                    receive_holding_word <= shift; // R8
                                    if (read_mode)
                                        receive_ready_flag <= 1'b1; // R9
                                end
                                if (!read_mode || addr_phase) begin
                                    if (sda_sync) begin
                                        not_acknowledged_flag_pending <= 1'b1; // R5
                                        state        <= ST_STOP;
                                    end else if (stop_request && !addr_phase) begin
                                        state <= ST_STOP;
                                    end else begin
                                        state               <= ST_BIT;
                                        shift               <= read_mode ? 8'hff : tx_data;
                                        transmit_ready_flag <= 1'b1;
                                    end
                                end else if (stop_request) begin
                                    state <= ST_STOP;
                                end else begin
                                    state <= ST_BIT;
                                    shift <= 8'hff;
                                end
                                addr_phase <= 1'b0;
                                bit_cnt    <= 4'h0;
                            end
                        end
                    end
                    ST_STOP: begin
                        if (!phase_high && phase_cnt == 16'h0000) begin
                            sda_oe  <= 1'b1;
                            sda_out <= 1'b0;
                        end
                        if (tick && !phase_high) begin
                            scl_oe     <= 1'b0;
                            scl_out    <= 1'b1;
                            phase_high <= 1'b1;
                        end else if (tick) begin
                            sda_oe                 <= 1'b0;
                            sda_out                <= 1'b1;
                            state                  <= ST_IDLE;
                            stop_request           <= 1'b0;
                            transfer_complete_flag <= 1'b1; // R6
                            // not_acknowledged_flag rises with complete unless a status read wiped it
                            if (not_acknowledged_flag_pending && !status_rd)
                                not_acknowledged_flag <= 1'b1; // R6
                            not_acknowledged_flag_pending <= 1'b0;
                        end
                    end
                    ST_STUCK: state <= ST_STUCK; // R11
                    default:  state <= ST_IDLE;
                endcase
            end
        end
    end

    // event bits follow the rising status flags; set wins over clear
    always @* begin
        next_event = event_status;
        if (wr && paddr == `OFF_INT_CLEAR)
            next_event = next_event & ~pwdata[2:0];
        if (state == ST_STOP && tick && phase_high && master_enabled && !freeze &&
            !soft_rst) begin
            next_event[`EV_COMPLETE] = 1'b1;
            if (not_acknowledged_flag_pending && !status_rd)
                next_event[`EV_NOT_ACKNOWLEDGED_FLAG] = 1'b1;
        end
        if (state == ST_ACK && tick && phase_high && read_mode && !addr_phase &&
            master_enabled && !freeze && !soft_rst)
            next_event[`EV_RX_READY] = 1'b1;
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            event_status <= 3'h0;
            irq          <= 1'b0;
        end else begin
            event_status <= next_event;
            irq          <= |(next_event & event_enable);
        end
    end

endmodule

//--- verification/twm_checker.sv
`timescale 1ns/10ps
`include "twi_master_regs.vh"
module twm_checker (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        scl_out,
    input wire        scl_oe,
    input wire        sda_out,
    input wire        sda_oe,
    input wire        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire wr  = psel && penable && pready && pwrite;
    wire dis = wr && paddr == `OFF_CONTROL && pwdata[`CTL_MASTER_DIS];
    property p_ready_one;
        psel && !penable |=> pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready missing after setup");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata nonzero while idle");
    property p_unmapped;
        psel && !penable && paddr == 12'h100 |=> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    // open drain: driving means pulling low, never driving high
    property p_drive_low;
        !((scl_oe && scl_out) || (sda_oe && sda_out));
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("pin driven high");
    property p_freeze;
        dis |=> ($stable(scl_oe) && $stable(sda_oe)) [*8];
    endproperty
    a_freeze: assert property (p_freeze) else $error("pins moved after disable");
    property p_flags_kept;
        dis |=> $stable(irq) [*4];
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("irq moved after disable");
    property p_irq_mask;
        wr && paddr == `OFF_INT_ENABLE && pwdata[2:0] == 3'h0 |-> ##[1:2] !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");
    property p_reset;
        disable iff (1'b0) !rst_n |=> !pready && !irq && !scl_oe && !sda_oe;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule

bind two_wire_master_controller twm_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

//--- verification/i2c_slave_model.sv
`timescale 1ns/10ps
module i2c_slave_model #(
    parameter [6:0] DEV_ADDR = 7'h2a
) (
    input  wire       scl,
    input  wire       sda,
    input  wire       not_acknowledged_flag_all,
    input  wire [7:0] read_byte,
    output reg        sda_pull = 1'b0,
    output reg  [7:0] last_rx = 8'h00
);
    reg [7:0] shreg   = 8'h00;
    integer   bits    = 0;
    reg       scl_q   = 1'b1;
    reg       sda_q   = 1'b1;
    reg       active  = 1'b0;
    reg       first   = 1'b0;
    reg       reading = 1'b0;
    always @(scl or sda) begin
        if (scl && scl_q && sda !== sda_q) begin
            // falling data with clock high is a start, rising is a stop
            active = !sda;
            first = 1'b1;
            bits = 0;
            sda_pull = 1'b0;
        end else if (scl && !scl_q && active) begin
            if (bits == 8 && reading && !first && sda)
                active = 1'b0;
            if (bits < 8)
                shreg = {shreg[6:0], sda};
            bits = bits + 1;
        end else if (!scl && scl_q && active) begin
            if (bits == 8) begin
                if (first)
                    reading = shreg[0];
                if (first && shreg[7:1] != DEV_ADDR)
                    active = 1'b0;
                else if (!first && !reading)
                    last_rx = shreg;
                sda_pull = active && !not_acknowledged_flag_all && !(reading && !first);
            end else if (bits == 9) begin
                bits = 0;
                first = 1'b0;
                sda_pull = reading && !read_byte[7];
            end else if (reading && !first) begin
                sda_pull = !read_byte[7 - bits];
            end
        end
        scl_q = scl;
        sda_q = sda;
    end
endmodule

//--- verification/two_wire_master_controller_tb_top.sv
`timescale 1ns/10ps
`include "twi_master_regs.vh"
module two_wire_master_controller_tb_top;
    localparam [31:0] EN = 32'h1 << `CTL_MASTER_EN;
    localparam [31:0] GO = EN | (32'h1 << `CTL_START) | (32'h1 << `CTL_STOP);
    localparam [31:0] WR_MODE = 32'h002a_0000;
    reg         sys_clk   = 1'b0;
    reg         rst_n     = 1'b0;
    reg         psel      = 1'b0;
    reg         penable   = 1'b0;
    reg         pwrite    = 1'b0;
    reg  [11:0] paddr     = 12'h000;
    reg  [31:0] pwdata    = 32'h0;
    reg  [7:0]  rd_byte   = 8'h3c;
    reg         not_acknowledged_flag_all  = 1'b0;
    wire [31:0] prdata;
    wire        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, slv_pull;
    wire [7:0]  slv_rx;
    wire        scl       = !scl_oe;
    wire        sda       = !(sda_oe || slv_pull);
    integer     bad_count = 0;
    integer     compares  = 0;
    integer     cycles    = 0;
    integer     low_run   = 0;
    integer     exp_low   = 0;
    reg  [31:0] rd;
    reg         err;

    two_wire_master_controller dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    i2c_slave_model slave (.scl(scl), .sda(sda), .not_acknowledged_flag_all(not_acknowledged_flag_all), .read_byte(rd_byte),
        .sda_pull(slv_pull), .last_rx(slv_rx));

    always #50 sys_clk = ~sys_clk;

    task close_out;
        begin
            $display("compares %0d mismatches %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task check32(input string what, input [31:0] expv, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== expv) begin
                bad_count = bad_count + 1;
                $display("ERROR %s expected %h seen %h", what, expv, got);
            end
        end
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count = bad_count + 1;
            close_out;
        end
        if (scl_oe)
            low_run <= low_run + 1;
        else if (low_run != 0) begin
            if (exp_low != 0)
                check32("scl low phase", exp_low, low_run);
            low_run <= 0;
        end
    end

    task apb(input [11:0] a, input w, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1)
                @(posedge sys_clk);
            check32("pready", 1, pready);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task rdchk(input string what, input [11:0] a, input [31:0] mask, input [31:0] expv);
        begin
            apb(a, 1'b0, 32'h0);
            check32(what, expv, rd & mask);
        end
    endtask

    task do_reset;
        begin
            rst_n <= 1'b0;
            repeat (12) @(posedge sys_clk);
            rst_n <= 1'b1;
            @(posedge sys_clk);
        end
    endtask

    task wait_irq;
        integer n;
        begin
            n = 0;
            while (irq !== 1'b1 && n < 3000) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            check32("irq raised", 1, irq);
        end
    endtask

    // events are cleared first so the interrupt reflects this frame only
    task xfer(input [31:0] mode, input [7:0] data);
        begin
            wr(`OFF_INT_CLEAR, 32'h7);
            wr(`OFF_CONTROL, EN);
            wr(`OFF_MODE, mode);
            wr(`OFF_TRANSMIT, {24'h0, data});
            wr(`OFF_CONTROL, GO);
        end
    endtask

    task wait_scl_low;
        integer n;
        begin
            n = 0;
            while (scl_oe !== 1'b1 && n < 500) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            // back at once: the next write lands while the clock is still held low
        end
    endtask

    task t_reset_values;
        begin
            rdchk("status reset", `OFF_STATUS, 32'h107, 32'h5);
            rdchk("clock reset", `OFF_CLOCK, 32'hffffffff, `CLOCK_RESET);
            apb(12'h100, 1'b0, 32'h0);
            check32("unmapped error", 1, err);
            check32("unmapped data", 0, rd);
        end
    endtask

    task t_write;
        begin
            wr(`OFF_CLOCK, 32'h0001_0203);
            exp_low = 6;
            wr(`OFF_INT_ENABLE, 32'h1);
            xfer(WR_MODE, 8'ha5);
            wait_irq;
            exp_low = 0;
            check32("slave byte", 8'ha5, slv_rx);
            rdchk("status after write", `OFF_STATUS, 32'h103, 32'h1);
            rdchk("receive after write", `OFF_RECEIVE, 32'hff, 32'ha5);
            wr(`OFF_INT_ENABLE, 32'h0);
            repeat (3) @(posedge sys_clk);
            check32("irq masked", 0, irq);
            wr(`OFF_INT_ENABLE, 32'h1);
            repeat (3) @(posedge sys_clk);
            check32("irq unmasked", 1, irq);
            wr(`OFF_INT_CLEAR, 32'h1);
            repeat (3) @(posedge sys_clk);
            check32("irq cleared", 0, irq);
            wr(`OFF_CLOCK, `CLOCK_RESET);
        end
    endtask

    task t_read;
        begin
            xfer(WR_MODE | 32'h1000, 8'h00);
            wait_irq;
            rdchk("status after read", `OFF_STATUS, 32'h3, 32'h3);
            rdchk("receive after read", `OFF_RECEIVE, 32'hff, 32'h3c);
            rdchk("rx ready cleared", `OFF_STATUS, 32'h2, 32'h0);
        end
    endtask

    task t_not_acknowledged_flag;
        begin
            not_acknowledged_flag_all <= 1'b1;
            wr(`OFF_INT_ENABLE, 32'h2);
            xfer(WR_MODE, 8'h77);
            wait_irq;
            rdchk("not_acknowledged_flag with complete", `OFF_STATUS, 32'h101, 32'h101);
            rdchk("not_acknowledged_flag after read", `OFF_STATUS, 32'h100, 32'h0);
            not_acknowledged_flag_all <= 1'b0;
        end
    endtask

    task t_freeze;
        begin
            wr(`OFF_INT_ENABLE, 32'h0);
            xfer(WR_MODE, 8'h55);
            wait_scl_low;
            wr(`OFF_CONTROL, 32'h1 << `CTL_MASTER_DIS);
            repeat (30) @(posedge sys_clk);
            check32("clock held by freeze", 1, scl_oe);
            rdchk("status after disable", `OFF_STATUS, 32'h107, 32'h0);
        end
    endtask

    task t_soft_reset;
        begin
            xfer(WR_MODE, 8'h66);
            wait_scl_low;
            wr(`OFF_CONTROL, 32'h1 << `CTL_SOFT_RESET);
            wr(`OFF_INT_ENABLE, 32'h1);
            xfer(WR_MODE, 8'h66);
            repeat (3000) @(posedge sys_clk);
            check32("irq after soft reset", 0, irq);
        end
    endtask

    initial begin
        do_reset;
        t_reset_values;
        t_write;
        t_read;
        t_not_acknowledged_flag;
        t_freeze;
        do_reset;
        t_soft_reset;
        close_out;
    end
endmodule
